// ===== shared/fsps_defines.svh
// Constants for the flash self-program sequencer
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH
// ***************************************************************
// Command patterns, low five control bits
// ***************************************************************
`define FSPS_CMD_LOAD     5'h01
`define FSPS_CMD_ERASE    5'h03
`define FSPS_CMD_WRITE    5'h05
`define FSPS_CMD_LOCK     5'h09
`define FSPS_CMD_REEN     5'h11
// ***************************************************************
// Windows in cycles
// ***************************************************************
`define FSPS_STORE_WIN    3'h4
`define FSPS_LOAD_WIN     3'h3
// ***************************************************************
// Readback pointers
// ***************************************************************
`define FSPS_PTR_FUSE_LO  16'h0000
`define FSPS_PTR_LOCK     16'h0001
`define FSPS_PTR_FUSE_EXT 16'h0002
`define FSPS_PTR_FUSE_HI  16'h0003
// ***************************************************************
// Programming time
// ***************************************************************
`define FSPS_PROG_NS      4500000
`define FSPS_CLK_NS       25
`define FSPS_PROG_CYC     (`FSPS_PROG_NS / `FSPS_CLK_NS)
`define FSPS_LOCK_RESET   8'hFF
`endif

// ===== shared/fsps_pkg.sv
// Types for the flash self-program sequencer
`default_nettype none
package fsps_pkg;
  typedef enum logic [2:0] {
    FSPS_IDLE  = 3'b000,
    FSPS_ARMED = 3'b001,
    FSPS_BUSY  = 3'b011,
    FSPS_DONE  = 3'b010
  } fsps_state_t;
  typedef enum logic [1:0] {
    FSPS_OP_ERASE = 2'h0,
    FSPS_OP_WRITE = 2'h1,
    FSPS_OP_LOCK  = 2'h2
  } fsps_op_t;
endpackage : fsps_pkg
`default_nettype wire

// ===== design/fsps_page_buf.sv
// Temporary page buffer with per-word valid bits
`timescale 1ns/100ps
`default_nettype none
module fsps_page_buf #(
  parameter int WORDS = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Access
  input  wire logic          clr,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [15:0]   rdata,
  output logic               rvalid
);
  logic [15:0]      mem [WORDS];
  logic [WORDS-1:0] vld_r;
  logic [WORDS-1:0] vld_nxt;
  logic [15:0]      rdata_r;
  logic             rvalid_r;

  always_comb begin
    vld_nxt = vld_r;
    if (clr) begin
      vld_nxt = '0;
    end else if (we) begin
      vld_nxt[waddr] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vld_r    <= '0;
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      vld_r    <= vld_nxt;
      rdata_r  <= vld_r[raddr] ? mem[raddr] : 16'hFFFF;
      rvalid_r <= vld_r[raddr];
    end
  end

  // Storage has no reset; the valid bits say what holds data
  always_ff @(posedge mclk) begin
    if (we && !clr) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata  = rdata_r;
  assign rvalid = rvalid_r;
endmodule : fsps_page_buf
`default_nettype wire

// ===== design/fsps_seq.sv
// Flash self-program sequencer top level
// Notes on behaviour
// - Buffer loads one word per store instruction, any order.
// - Erase pattern then store within four cycles erases addressed page.
// - Halting-section target stalls the core until the operation ends.
// - Load pattern then store writes data pair at word address.
// - Buffer clears after page write, on re-enable, and on reset.
// - EEPROM write starting during buffer load discards buffer data.
// - Write pattern then store programs addressed page from buffer.
// - Ready interrupt held while enabled and store enable reads clear.
// - Erase or write of a page below HALT_PAGE0 sets concurrent-read busy.
// - Lock pattern then store programs boot lock bits whose source is zero.
// - Lock programming blocks no section.
// - EEPROM write busy refuses all commands and readbacks.
// - Lock-set readback at pointer 0x0001 within three cycles returns lock byte.
// - Lock-set and store enable self-clear on readback or window timeout.
// - Pointers 0x0000, 0x0003, 0x0002 return low, high, extended fuses.
// - Returned fuse and lock bits read zero when programmed.
// - With both bits clear, loads read the flash array.
// - Starting a buffer load clears concurrent-read busy.
// - Store enable stays set through erase or write, then clears.
// - Undefined low five control patterns have no effect.
// - Re-enable written during buffer load aborts it and drops data.
`timescale 1ns/100ps
`default_nettype none
`include "fsps_defines.svh"
module fsps_seq #(
  parameter int PAGE_AW   = 8,
  parameter int WORD_AW   = 6,
  parameter int PROG_CYC  = `FSPS_PROG_CYC,
  parameter logic [PAGE_AW-1:0] HALT_PAGE0 = 8'hF0
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Control register write from the core
  input  wire logic               ctl_we,
  input  wire logic [7:0]         ctl_wdata,
  output logic      [7:0]         ctl_rdata,
  // Store and load instructions
  input  wire logic               store_exec,
  input  wire logic               load_exec,
  input  wire logic [15:0]        z_ptr,
  input  wire logic [15:0]        data_word_pair,
  input  wire logic [7:0]         flash_rdata,
  output logic      [7:0]         load_rdata,
  output logic                    load_special,
  // EEPROM status
  input  wire logic               eeprom_write_busy,
  input  wire logic               eeprom_write_start,
  // Fuses as stored, zero means programmed
  input  wire logic [7:0]         fuse_low_byte,
  input  wire logic [7:0]         fuse_high_byte,
  input  wire logic [2:0]         fuse_extended_byte,
  input  wire logic [1:0]         memory_lock,
  // Flash array side
  output logic                    flash_erase,
  output logic                    flash_write,
  output logic [PAGE_AW-1:0]      flash_page,
  input  wire logic [WORD_AW-1:0] flash_word,
  output logic      [15:0]        flash_wdata,
  output logic                    flash_wvalid,
  // Status to the core
  output logic                    core_stall,
  output logic                    concurrent_read_busy,
  output logic                    store_ready_irq,
  output logic      [3:0]         boot_lock
);
  // ***************************************************************
  // State
  // ***************************************************************
  fsps_pkg::fsps_state_t st_r, st_nxt;
  fsps_pkg::fsps_op_t    op_r, op_nxt;
  logic [4:0]            cmd_r, cmd_nxt;
  logic                  irq_en_r, irq_en_nxt;
  logic                  busy_r, busy_nxt;
  logic                  stall_r, stall_nxt;
  logic [2:0]            win_r, win_nxt;
  logic [31:0]           cnt_r, cnt_nxt;
  logic [PAGE_AW-1:0]    page_r, page_nxt;
  logic [3:0]            blk_r, blk_nxt;
  logic [7:0]            rd_r, rd_nxt;
  logic                  spec_r, spec_nxt;
  logic                  loading_r, loading_nxt;
  logic                  buf_clr, buf_we;
  logic                  store_en;
  logic                  cmd_ok;
  logic [PAGE_AW-1:0]    z_page;

  assign z_page   = z_ptr[WORD_AW+PAGE_AW:WORD_AW+1];
  assign store_en = (st_r != fsps_pkg::FSPS_IDLE);
  assign cmd_ok = (ctl_wdata[4:0] == `FSPS_CMD_LOAD)  ||
                  (ctl_wdata[4:0] == `FSPS_CMD_ERASE) ||
                  (ctl_wdata[4:0] == `FSPS_CMD_WRITE) ||
                  (ctl_wdata[4:0] == `FSPS_CMD_LOCK)  ||
                  (ctl_wdata[4:0] == `FSPS_CMD_REEN);

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    st_nxt      = st_r;
    op_nxt      = op_r;
    cmd_nxt     = cmd_r;
    irq_en_nxt  = irq_en_r;
    busy_nxt    = busy_r;
    stall_nxt   = stall_r;
    win_nxt     = win_r;
    cnt_nxt     = cnt_r;
    page_nxt    = page_r;
    blk_nxt     = blk_r;
    rd_nxt      = rd_r;
    spec_nxt    = 1'b0;
    loading_nxt = loading_r;
    buf_clr     = 1'b0;
    buf_we      = 1'b0;
    if (ctl_we) begin
      irq_en_nxt = ctl_wdata[7];
    end
    case (st_r)
      fsps_pkg::FSPS_IDLE: begin
        if (ctl_we && cmd_ok && !eeprom_write_busy) begin
          cmd_nxt = ctl_wdata[4:0];
          win_nxt = `FSPS_STORE_WIN;
          st_nxt  = fsps_pkg::FSPS_ARMED;
        end
      end
      fsps_pkg::FSPS_ARMED: begin
        win_nxt = win_r - 3'h1;
        if (store_exec && !eeprom_write_busy) begin
          st_nxt = fsps_pkg::FSPS_IDLE;
          case (cmd_r)
            `FSPS_CMD_LOAD: begin
              buf_we      = 1'b1;
              loading_nxt = 1'b1;
              busy_nxt    = 1'b0;
            end
            `FSPS_CMD_REEN: begin
              buf_clr     = 1'b1;
              loading_nxt = 1'b0;
              busy_nxt    = 1'b0;
            end
            `FSPS_CMD_ERASE, `FSPS_CMD_WRITE: begin
              page_nxt  = z_page;
              op_nxt    = (cmd_r == `FSPS_CMD_ERASE) ?
                          fsps_pkg::FSPS_OP_ERASE : fsps_pkg::FSPS_OP_WRITE;
              stall_nxt = (z_page >= HALT_PAGE0);
              busy_nxt  = (z_page < HALT_PAGE0);
              cnt_nxt   = 32'(PROG_CYC);
              st_nxt    = fsps_pkg::FSPS_BUSY;
            end
            default: begin
              blk_nxt = blk_r & data_word_pair[5:2];
              op_nxt  = fsps_pkg::FSPS_OP_LOCK;
              cnt_nxt = 32'(PROG_CYC);
              st_nxt  = fsps_pkg::FSPS_BUSY;
            end
          endcase
        end else if (load_exec && cmd_r == `FSPS_CMD_LOCK &&
                     win_r > 3'h1 && !eeprom_write_busy) begin
          spec_nxt = 1'b1;
          case (z_ptr)
            `FSPS_PTR_FUSE_LO:  rd_nxt = fuse_low_byte;
            `FSPS_PTR_LOCK:     rd_nxt = {2'b11, blk_r, memory_lock};
            `FSPS_PTR_FUSE_EXT: rd_nxt = {5'b11111, fuse_extended_byte};
            `FSPS_PTR_FUSE_HI:  rd_nxt = fuse_high_byte;
            default:            rd_nxt = `FSPS_LOCK_RESET;
          endcase
          st_nxt = fsps_pkg::FSPS_IDLE;
        end else if (win_r == 3'h1) begin
          st_nxt = fsps_pkg::FSPS_IDLE;
        end
      end
      fsps_pkg::FSPS_BUSY: begin
        if (cnt_r <= 32'h1) begin
          st_nxt = fsps_pkg::FSPS_DONE;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      fsps_pkg::FSPS_DONE: begin
        stall_nxt = 1'b0;
        if (op_r == fsps_pkg::FSPS_OP_WRITE) begin
          buf_clr     = 1'b1;
          loading_nxt = 1'b0;
        end
        st_nxt = fsps_pkg::FSPS_IDLE;
      end
      default: st_nxt = fsps_pkg::FSPS_IDLE;
    endcase
    // EEPROM write during load drops buffer
    if (eeprom_write_start && loading_r) begin
      buf_clr     = 1'b1;
      loading_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r      <= fsps_pkg::FSPS_IDLE;
      op_r      <= fsps_pkg::FSPS_OP_ERASE;
      cmd_r     <= 5'h00;
      irq_en_r  <= 1'b0;
      busy_r    <= 1'b0;
      stall_r   <= 1'b0;
      win_r     <= 3'h0;
      cnt_r     <= 32'h0;
      page_r    <= '0;
      blk_r     <= 4'hF;
      rd_r      <= 8'h00;
      spec_r    <= 1'b0;
      loading_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      op_r      <= op_nxt;
      cmd_r     <= cmd_nxt;
      irq_en_r  <= irq_en_nxt;
      busy_r    <= busy_nxt;
      stall_r   <= stall_nxt;
      win_r     <= win_nxt;
      cnt_r     <= cnt_nxt;
      page_r    <= page_nxt;
      blk_r     <= blk_nxt;
      rd_r      <= rd_nxt;
      spec_r    <= spec_nxt;
      loading_r <= loading_nxt;
    end
  end

  // ***************************************************************
  // Temporary buffer
  // ***************************************************************
  // reset clears valid bits
  fsps_page_buf #(
    .WORDS (1 << WORD_AW),
    .AW    (WORD_AW)
  ) u_buf (
    .mclk   (mclk),
    .rst    (rst),
    .clr    (buf_clr),
    .we     (buf_we),
    .waddr  (z_ptr[WORD_AW:1]),
    .wdata  (data_word_pair),
    .raddr  (flash_word),
    .rdata  (flash_wdata),
    .rvalid (flash_wvalid)
  );

  // ***************************************************************
  // Outputs
  // ***************************************************************
  logic in_armed;
  assign in_armed = (st_r == fsps_pkg::FSPS_ARMED);
  assign ctl_rdata = {irq_en_r, busy_r, 1'b0,
                      in_armed ? cmd_r : {4'h0, store_en}};
  assign load_rdata   = spec_r ? rd_r : flash_rdata;
  assign load_special = spec_r;
  assign flash_erase  = (st_r == fsps_pkg::FSPS_BUSY) &&
                        (op_r == fsps_pkg::FSPS_OP_ERASE);
  assign flash_write  = (st_r == fsps_pkg::FSPS_BUSY) &&
                        (op_r == fsps_pkg::FSPS_OP_WRITE);
  assign flash_page   = page_r;
  assign core_stall   = stall_r;
  assign concurrent_read_busy = busy_r;
  assign store_ready_irq = irq_en_r && !store_en;
  assign boot_lock       = blk_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  irq_level_a: assert property (store_ready_irq ==
                                (ctl_rdata[7] && !ctl_rdata[0]))
    else $error("irq level wrong");
  armed_win_a: assert property ($rose(in_armed) |-> ##[1:4] !in_armed)
    else $error("window too long");
  eep_refuse_a: assert property (eeprom_write_busy && !store_en |=>
                                 !in_armed)
    else $error("armed while eeprom busy");
  one_op_a: assert property (st_r == fsps_pkg::FSPS_BUSY && ctl_we |=>
                             cmd_r == $past(cmd_r))
    else $error("command taken while busy");
  lock_noblk_a: assert property (op_r == fsps_pkg::FSPS_OP_LOCK &&
                                 st_r == fsps_pkg::FSPS_BUSY |->
                                 !core_stall &&
                                 $stable(concurrent_read_busy))
    else $error("lock blocked section");
  busy_hold_a: assert property ($fell(flash_erase || flash_write) |->
                                ctl_rdata[0] ##1 !ctl_rdata[0])
    else $error("store enable dropped");
  bad_cmd_a: assert property (!store_en && ctl_we && !cmd_ok |=> !store_en)
    else $error("bad pattern accepted");
  load_clr_a: assert property (in_armed && store_exec && !eeprom_write_busy
                               && cmd_r == `FSPS_CMD_LOAD |=> !busy_r)
    else $error("load kept busy");
  rb_lock_a: assert property (in_armed && load_exec && win_r > 3'h1 &&
                              cmd_r == `FSPS_CMD_LOCK && !store_exec &&
                              !eeprom_write_busy &&
                              z_ptr == `FSPS_PTR_LOCK
                              |=> load_rdata[5:2] == blk_r)
    else $error("lock readback wrong");

  erase_c: cover property (flash_erase);
  write_c: cover property (flash_write ##[1:8] !store_en);
  rb_c: cover property (load_special);
  lock_c: cover property (op_r == fsps_pkg::FSPS_OP_LOCK && store_en);
endmodule : fsps_seq
`default_nettype wire

// ===== tb/fsps_core_model.sv
// Core model issuing control writes, stores and loads
`timescale 1ns/100ps
`default_nettype none
module fsps_core_model (
  // Clock
  input  wire logic   mclk,
  // Requests to the sequencer
  output logic        ctl_we,
  output logic [7:0]  ctl_wdata,
  output logic        store_exec,
  output logic        load_exec,
  output logic [15:0] z_ptr,
  output logic [15:0] data_word_pair
);
  initial begin
    ctl_we         = 1'b0;
    ctl_wdata      = 8'h00;
    store_exec     = 1'b0;
    load_exec      = 1'b0;
    z_ptr          = 16'h0000;
    data_word_pair = 16'h0000;
  end
  // order and values come from the caller
  // Kind 0 control only, 1 store, 2 load; gap idles first
  task automatic spm(input logic [7:0] c, input logic [15:0] z, d,
                     input int kind, input int gap);
    @(negedge mclk);
    ctl_we         = 1'b1;
    ctl_wdata      = c;
    z_ptr          = z;
    data_word_pair = d;
    @(negedge mclk);
    ctl_we = 1'b0;
    repeat (gap) @(negedge mclk);
    store_exec = (kind == 1);
    load_exec  = (kind == 2);
    @(negedge mclk);
    store_exec = 1'b0;
    load_exec  = 1'b0;
    // page is latched, so the pointer moves on at once
    z_ptr          = ~z;
    data_word_pair = ~d;
  endtask : spm
endmodule : fsps_core_model
`default_nettype wire

// ===== tb/fsps_seq_test.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/100ps
`default_nettype none
module fsps_seq_test;
  // ***************************************************
  // Signals
  // ***************************************************
  localparam int         PROG     = 20;
  localparam logic [7:0] LOCK_SRC = 8'hEB;
  logic        mclk, rst, ctl_we, store_exec, load_exec, flash_op;
  logic        ee_busy, ee_start, flash_erase, flash_write;
  logic        flash_wvalid, core_stall, crw_busy, irq, load_special;
  logic [7:0]  ctl_wdata, ctl_rdata, flash_rdata, load_rdata;
  logic [7:0]  fuse_lo, fuse_hi, flash_page;
  logic [2:0]  fuse_ext;
  logic [1:0]  mem_lock;
  logic [3:0]  boot_lock;
  logic [5:0]  flash_word;
  logic [15:0] z_ptr, dwp, flash_wdata;
  int          num_errors, n_tests;
  typedef struct packed {
    logic [15:0] z;
    logic [7:0]  exp;
    logic [7:0]  mask;
  } fsps_row_t;
  fsps_row_t   rows [5];
  assign flash_op = (flash_erase | flash_write) === 1'b1;
  always #12.5 mclk = ~mclk;
  fsps_core_model core (.mclk(mclk), .ctl_we(ctl_we),
    .ctl_wdata(ctl_wdata), .store_exec(store_exec),
    .load_exec(load_exec), .z_ptr(z_ptr), .data_word_pair(dwp));
  fsps_seq #(.PROG_CYC(PROG)) DUT (.mclk(mclk), .rst(rst),
    .ctl_we(ctl_we), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
    .store_exec(store_exec), .load_exec(load_exec), .z_ptr(z_ptr),
    .data_word_pair(dwp), .flash_rdata(flash_rdata),
    .load_rdata(load_rdata), .load_special(load_special),
    .eeprom_write_busy(ee_busy), .eeprom_write_start(ee_start),
    .fuse_low_byte(fuse_lo), .fuse_high_byte(fuse_hi),
    .fuse_extended_byte(fuse_ext), .memory_lock(mem_lock),
    .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_page(flash_page), .flash_word(flash_word),
    .flash_wdata(flash_wdata), .flash_wvalid(flash_wvalid),
    .core_stall(core_stall), .concurrent_read_busy(crw_busy),
    .store_ready_irq(irq), .boot_lock(boot_lock));
  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic check(input logic [16:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // Sel 0 idle, 1 operation running, 2 readback ready
  task automatic wait_for(input int sel);
    for (int i = 0; i < 100; i++) begin
      if ((sel == 0 && ctl_rdata[0] === 1'b0 && !flash_op) ||
          (sel == 1 && (flash_op || ctl_rdata[0] === 1'b1)) ||
          (sel == 2 && load_special === 1'b1)) begin
        // Idle seen; wait one more cycle before returning
        if (sel == 0)
          @(negedge mclk);
        return;
      end
      @(negedge mclk);
    end
    num_errors++;
    $display("[ERR] %0t timeout waiting %0d", $time, sel);
    results();
  endtask : wait_for
  task automatic word_is(input logic [5:0] w, input logic [16:0] exp);
    flash_word = w;
    repeat (2) @(negedge mclk);
    check({flash_wvalid, flash_wdata}, exp, "buffer word");
  endtask : word_is
  // ***************************************************
  // Sequence
  // ***************************************************
  initial begin
    {mclk, ee_busy, ee_start, num_errors, n_tests} = '0;
    {fuse_lo, fuse_hi, fuse_ext, mem_lock} = {8'h5E, 8'h99, 3'h3, 2'h2};
    {rst, flash_rdata, flash_word} = {1'b1, 8'h3C, 6'h00};
    rows[0] = '{16'h0000, fuse_lo, 8'hFF};
    rows[1] = '{16'h0001, {2'b11, LOCK_SRC[5:2], mem_lock}, 8'hFF};
    rows[2] = '{16'h0002, {5'h00, fuse_ext}, 8'h07};
    rows[3] = '{16'h0003, fuse_hi, 8'hFF};
    rows[4] = '{16'h0005, 8'hFF, 8'hFF};
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    check(ctl_rdata, 8'h00, "reset ctl");
    check(boot_lock, 4'hF, "reset lock");
    word_is(6'h00, 17'h0FFFF);
    core.spm(8'h09, 16'h0001, {8'hFF, LOCK_SRC}, 1, 0);
    wait_for(1);
    check({crw_busy, core_stall}, 2'b00, "lock blocks");
    wait_for(0);
    check(boot_lock, LOCK_SRC[5:2], "lock set");
    for (int i = 0; i < 5; i++) begin
      core.spm(8'h09, rows[i].z, 16'hFFFF, 2, 0);
      wait_for(2);
      check(load_rdata & rows[i].mask, rows[i].exp, "readback");
      @(negedge mclk);
      check(ctl_rdata[0], 1'b0, "readback clear");
    end
    core.spm(8'h09, 16'h0001, 16'hFFFF, 0, 0);
    repeat (5) @(negedge mclk);
    check(ctl_rdata[0], 1'b0, "load window");
    core.spm(8'h09, 16'h0001, 16'hFFFF, 2, 3);
    check(load_special, 1'b0, "late load");
    core.spm(8'h09, 16'h0001, 16'hFFFF, 2, 2);
    check(load_special, 1'b1, "last load slot");
    core.spm(8'h07, 16'h0001, 16'hFFFF, 2, 0);
    repeat (2) @(negedge mclk);
    check(ctl_rdata[0], 1'b0, "bad pattern");
    check(load_rdata, flash_rdata, "array read");
    core.spm(8'h01, 16'h000A, 16'h1234, 1, 2);
    core.spm(8'h01, 16'h0005, 16'hBEEF, 1, 0);
    core.spm(8'h03, 16'h0180, 16'hFFFF, 1, 0);
    wait_for(0);
    check(crw_busy, 1'b1, "erase busy");
    core.spm(8'h85, 16'h0180, 16'h0000, 1, 0);
    wait_for(1);
    check({flash_write, flash_page}, 9'h103, "page write");
    check({crw_busy, core_stall, irq}, 3'b100, "write busy");
    check(ctl_rdata[0], 1'b1, "store en held");
    check(ctl_rdata[7:6], 2'b11, "ctl flags");
    word_is(6'h05, 17'h11234);
    word_is(6'h02, 17'h1BEEF);
    core.spm(8'h89, 16'h0001, 16'h00C3, 1, 0);
    wait_for(0);
    check(boot_lock, LOCK_SRC[5:2], "busy refuse");
    check({irq, crw_busy}, 2'b11, "done irq");
    word_is(6'h05, 17'h0FFFF);
    core.spm(8'h11, 16'h0000, 16'h0000, 1, 0);
    wait_for(0);
    check(crw_busy, 1'b0, "reenable");
    core.spm(8'h03, 16'h7800, 16'hFFFF, 1, 0);
    wait_for(1);
    check({flash_erase, core_stall, flash_page}, 10'h3F0, "halt erase");
    wait_for(0);
    check(core_stall, 1'b0, "stall end");
    core.spm(8'h03, 16'h0200, 16'hFFFF, 1, 0);
    wait_for(1);
    check({crw_busy, core_stall}, 2'b10, "rww erase");
    wait_for(0);
    core.spm(8'h01, 16'h0002, 16'h5555, 1, 0);
    wait_for(0);
    check(crw_busy, 1'b0, "load clears");
    word_is(6'h01, 17'h15555);
    ee_start = 1'b1;
    @(negedge mclk);
    ee_start = 1'b0;
    word_is(6'h01, 17'h0FFFF);
    core.spm(8'h01, 16'h0004, 16'hA5A5, 1, 0);
    core.spm(8'h11, 16'h0000, 16'h0000, 1, 0);
    wait_for(0);
    word_is(6'h02, 17'h0FFFF);
    ee_busy = 1'b1;
    core.spm(8'h03, 16'h0180, 16'hFFFF, 1, 0);
    repeat (2) @(negedge mclk);
    check({flash_erase, ctl_rdata[0]}, 2'b00, "ee refuse");
    core.spm(8'h09, 16'h0000, 16'hFFFF, 2, 0);
    repeat (2) @(negedge mclk);
    check(load_rdata, flash_rdata, "ee readback");
    ee_busy = 1'b0;
    core.spm(8'h03, 16'h0180, 16'hFFFF, 1, 6);
    repeat (2) @(negedge mclk);
    check(flash_erase, 1'b0, "late store");
    core.spm(8'h01, 16'h0006, 16'h7777, 1, 0);
    wait_for(0);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    word_is(6'h03, 17'h0FFFF);
    results();
  end
endmodule : fsps_seq_test
`default_nettype wire
